// [common/ucc_pkg.sv]
// package for the unified cache controller: geometry, field codes, carriers
// assumes a single 125 MHz clock domain and word-aligned core accesses
package ucc_pkg;
  localparam int UCC_ADDR_W = 32;
  localparam int UCC_DATA_W = 32;
  localparam int UCC_WAYS = 4;
  localparam int UCC_CACHE_BYTES = 2048;
  localparam int UCC_LINE_BYTES = 16;
  localparam int UCC_WORDS = UCC_LINE_BYTES / 4;
  localparam int UCC_SETS = UCC_CACHE_BYTES / (UCC_LINE_BYTES * UCC_WAYS);
  localparam int UCC_INDEX_W = 5;
  localparam int UCC_WAY_W = 2;
  localparam int UCC_OFF_LO = 2;
  localparam int UCC_OFF_W = 2;
  localparam int UCC_IDX_LO = UCC_OFF_LO + UCC_OFF_W;
  localparam int UCC_TAG_LO = UCC_IDX_LO + UCC_INDEX_W;
  localparam int UCC_TAG_W = UCC_ADDR_W - UCC_TAG_LO;
  localparam int UCC_CNT_W = 32;

  // monitor mode field codes
  localparam logic [1:0] UCC_MODE_CYCLE = 2'h0;
  localparam logic [1:0] UCC_MODE_IHIT = 2'h1;
  localparam logic [1:0] UCC_MODE_DHIT = 2'h2;

  // core-side request
  typedef struct packed {
    logic [UCC_ADDR_W-1:0] addr;
    logic write;
    logic instr;
    logic [UCC_DATA_W-1:0] wdata;
  } ucc_req_t;

  // single-line invalidate command: way and index
  typedef struct packed {
    logic [UCC_WAY_W-1:0] way;
    logic [UCC_INDEX_W-1:0] index;
  } ucc_inval_t;
endpackage : ucc_pkg

// [design/ucc_top.sv]
// unified 4-way cache between a core slave port and a 32-bit bus master
// assumes a valid/ready core port and a valid/ready memory master port
// assumes the far side stalls whenever clk_en holds this block frozen
//
// Summary of operation
// - unified instruction and data store, four ways
// - total data capacity of two kilobytes
// - sixteen-byte lines, fill moves four words
// - memory reached through 32-bit master port
// - index and tag taken from physical address
// - writes forwarded, cache state left untouched
// - victim way chosen by round-robin counter
// - reset invalidates all, cache enabled
// - disabled cache forwards every access unchanged
// - line invalidate clears valid when idle, counter points there
// - invalidate-all bit clears every valid bit
// - one 32-bit counter: cycles, instruction or data hits
// - counter runs only once monitor enabled
// - monitor clear bit zeroes the counter
// - counter value readable as status field
// - control bits apart from cached data path
// - way field selects way zero to three
// - mode codes: cycles 0, instr 1, data 2
// - line index field is five bits
`timescale 1ns/10ps
`default_nettype none
module ucc_top
  import ucc_pkg::*;
#(
  parameter int WAYS = UCC_WAYS,
  parameter int SETS = UCC_SETS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // core slave port
  input wire logic core_valid,
  input wire ucc_req_t core_req,
  output logic core_ready,
  output logic [UCC_DATA_W-1:0] core_rdata,
  // master port
  output logic mem_valid,
  output logic mem_write,
  output logic [UCC_ADDR_W-1:0] mem_addr,
  output logic [UCC_DATA_W-1:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [UCC_DATA_W-1:0] mem_rdata,
  // control and maintenance bits, kept off the data path
  input wire logic cache_enable_bit,
  output logic cache_status_bit,
  input wire logic invalidate_all_bit,
  input wire logic inval_line_wr,
  input wire ucc_inval_t inval_line,
  input wire logic [1:0] monitor_mode,
  input wire logic monitor_enable_bit,
  input wire logic monitor_clear_bit,
  output logic [UCC_CNT_W-1:0] monitor_count_field
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (WAYS != UCC_WAYS || SETS != (1 << UCC_INDEX_W))
    $error("ucc_top: geometry must be 4 ways of 32 sets");
  if (WAYS * SETS * UCC_LINE_BYTES != UCC_CACHE_BYTES)
    $error("ucc_top: ways, sets and line size miss the capacity");
  if (UCC_WORDS != (1 << UCC_OFF_W))
    $error("ucc_top: line words and offset width disagree");
  if (UCC_LINE_BYTES != (UCC_WORDS << UCC_OFF_LO))
    $error("ucc_top: a line must hold whole master words");
  if ((1 << UCC_WAY_W) != WAYS)
    $error("ucc_top: way field cannot name every way");
  if (UCC_TAG_W < 1)
    $error("ucc_top: no address bits left for the tag");
  if (UCC_CNT_W != UCC_DATA_W)
    $error("ucc_top: monitor counter must match the data width");

  typedef enum {ST_IDLE, ST_LOOK, ST_PASS, ST_FILL, ST_RESP} ucc_state_t;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // 4 ways x 32 sets x 4 words make the two-kilobyte store
  // arrays carry no reset: a cleared valid bit makes their contents unused
  logic [UCC_DATA_W-1:0] data_mem [WAYS*SETS*UCC_WORDS];
  logic [UCC_TAG_W-1:0] tag_mem [WAYS*SETS];
  logic [WAYS*SETS-1:0] valid;
  // one round-robin pointer per set, advanced after each fill
  logic [UCC_WAY_W-1:0] rr_ptr [SETS];

  ucc_state_t state;
  ucc_req_t req;
  logic [UCC_OFF_W-1:0] fill_cnt;
  logic [UCC_WAY_W-1:0] victim;

  // flat line number in the way-major tag, valid and data arrays
  function automatic int slot(input logic [UCC_WAY_W-1:0] w,
                              input logic [UCC_INDEX_W-1:0] i);
    slot = int'(w) * SETS + int'(i);
  endfunction : slot

  // ----------------------------------------------------------------
  // lookup decode on physical address
  // ----------------------------------------------------------------
  wire [UCC_INDEX_W-1:0] req_idx = req.addr[UCC_TAG_LO-1:UCC_IDX_LO];
  wire [UCC_TAG_W-1:0] req_tag = req.addr[UCC_ADDR_W-1:UCC_TAG_LO];
  wire [UCC_OFF_W-1:0] req_off = req.addr[UCC_IDX_LO-1:UCC_OFF_LO];
  logic [WAYS-1:0] way_hit;
  for (genvar g = 0; g < WAYS; g++) begin : g_cmp
    assign way_hit[g] = valid[g*SETS + int'(req_idx)]
                        && tag_mem[g*SETS + int'(req_idx)] == req_tag;
  end
  // at most one way can match, so the loop order never matters
  logic [UCC_WAY_W-1:0] hit_way;
  always_comb begin
    hit_way = '0;
    for (int k = 0; k < WAYS; k++) begin
      if (way_hit[k]) begin
        hit_way = UCC_WAY_W'(k);
      end
    end
  end
  wire any_hit = |way_hit;
  wire look_hit = state == ST_LOOK && any_hit;
  // word picked from the hit way at the request's offset
  wire [UCC_DATA_W-1:0] hit_data =
    data_mem[slot(hit_way, req_idx)*UCC_WORDS + int'(req_off)];
  wire mem_done = mem_valid && mem_ready;
  wire last_beat = fill_cnt == UCC_OFF_W'(UCC_WORDS-1);

  // ----------------------------------------------------------------
  // request classes and next values
  // ----------------------------------------------------------------
  wire beat_done = state == ST_FILL && mem_done;
  wire want_word = fill_cnt == req_off;
  wire [UCC_OFF_W-1:0] next_fill_cnt = fill_cnt + 1'b1;
  wire [UCC_ADDR_W-1:0] next_beat_addr =
    mem_addr + UCC_ADDR_W'(UCC_LINE_BYTES / UCC_WORDS);
  wire [UCC_WAY_W-1:0] next_rr = victim + 1'b1;
  // while core_ready stands, core_valid still carries the request just
  // answered; taking it then would run the same access twice
  wire take = state == ST_IDLE && core_valid && !core_ready;
  // writes and disabled accesses skip the lookup; a write leaves any cached
  // copy of its word stale until software invalidates the line
  wire byp_req = core_req.write || !cache_enable_bit;
  wire [UCC_ADDR_W-1:0] line_base = {req.addr[UCC_ADDR_W-1:UCC_IDX_LO],
                                     {UCC_IDX_LO{1'b0}}};

  // ----------------------------------------------------------------
  // control state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      req <= '0;
      fill_cnt <= '0;
      victim <= '0;
      core_ready <= 1'b0;
      core_rdata <= '0;
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
    end else if (clk_en) begin
      core_ready <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            req <= core_req;
            if (byp_req) begin
              state <= ST_PASS;
              mem_valid <= 1'b1;
              mem_write <= core_req.write;
              mem_addr <= core_req.addr;
              mem_wdata <= core_req.wdata;
            end else begin
              state <= ST_LOOK;
            end
          end
        end
        ST_LOOK: begin
          if (any_hit) begin
            core_rdata <= hit_data;
            core_ready <= 1'b1;
            state <= ST_IDLE;
          end else begin
            // victim fixed here, so a later pointer move cannot shift it
            victim <= rr_ptr[req_idx];
            fill_cnt <= '0;
            mem_valid <= 1'b1;
            mem_write <= 1'b0;
            mem_addr <= line_base;
            state <= ST_FILL;
          end
        end
        // single beat; a write answer carries no data for the core
        ST_PASS: begin
          if (mem_done) begin
            mem_valid <= 1'b0;
            core_rdata <= mem_rdata;
            core_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        // a miss streams the whole line from its base, word 0 first; the
        // requested word is caught as it passes, so the answer waits for
        // the last beat rather than for the wanted word
        ST_FILL: begin
          if (mem_done) begin
            if (want_word) begin
              core_rdata <= mem_rdata;
            end
            fill_cnt <= next_fill_cnt;
            mem_addr <= next_beat_addr;
            if (last_beat) begin
              mem_valid <= 1'b0;
              state <= ST_RESP;
            end
          end
        end
        // core_ready rises two cycles after the last beat, once the line is whole
        ST_RESP: begin
          core_ready <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // array writes: fill data, tags
  // ----------------------------------------------------------------
  // clk_en low freezes this side only: a ready pulse that arrives while
  // frozen is not seen, so the far side must stall with it
  wire fill_wr = clk_en && beat_done;
  always_ff @(posedge core_clk) begin
    if (fill_wr) begin
      data_mem[slot(victim, req_idx)*UCC_WORDS + int'(fill_cnt)] <= mem_rdata;
      if (last_beat) begin
        tag_mem[slot(victim, req_idx)] <= req_tag;
      end
    end
  end

  // ----------------------------------------------------------------
  // valid bits and replacement pointers
  // ----------------------------------------------------------------
  wire fill_end = fill_wr && last_beat;
  // line invalidate honoured only when idle, so no fill can race it
  wire line_inv = inval_line_wr && state == ST_IDLE;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid <= '0;
      for (int s = 0; s < SETS; s++) begin
        rr_ptr[s] <= '0;
      end
    end else if (clk_en) begin
      // invalidate-all outranks a fill that ends in the same cycle
      if (invalidate_all_bit) begin
        valid <= '0;
      end else begin
        if (fill_end) begin
          valid[slot(victim, req_idx)] <= 1'b1;
          rr_ptr[req_idx] <= next_rr;
        end
        if (line_inv) begin
          valid[slot(inval_line.way, inval_line.index)] <= 1'b0;
          rr_ptr[inval_line.index] <= inval_line.way;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status and monitor
  // ----------------------------------------------------------------
  wire idle_now = state == ST_IDLE && !take;
  // hits are counted in the lookup cycle, once per cached read
  wire ihit_ev = look_hit && req.instr;
  wire dhit_ev = look_hit && !req.instr;
  wire count_ev = monitor_mode == UCC_MODE_CYCLE
               || (monitor_mode == UCC_MODE_IHIT && ihit_ev)
               || (monitor_mode == UCC_MODE_DHIT && dhit_ev);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cache_status_bit <= 1'b1;
      monitor_count_field <= '0;
    end else if (clk_en) begin
      // status rises with enable at once, drops only when nothing is in flight
      if (cache_enable_bit) begin
        cache_status_bit <= 1'b1;
      end else if (idle_now) begin
        cache_status_bit <= 1'b0;
      end
      // clear outranks counting; the count wraps at full scale silently
      if (monitor_clear_bit) begin
        monitor_count_field <= '0;
      end else if (monitor_enable_bit && count_ev) begin
        monitor_count_field <= monitor_count_field + 1'b1;
      end
    end
  end
endmodule : ucc_top
`default_nettype wire

// [verif/ucc_mem_model.sv]
// bus matrix model for the cache master port, data derived from address
// assumes the design holds mem_valid and its qualifiers until mem_ready
`timescale 1ns/10ps
`default_nettype none
module ucc_mem_model
  import ucc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [UCC_DATA_W-1:0] salt,
  input wire logic mem_valid,
  input wire logic [UCC_ADDR_W-1:0] mem_addr,
  output logic mem_ready,
  output logic [UCC_DATA_W-1:0] mem_rdata
);
  // ---------------------
  // responder
  // ---------------------
  logic tog;
  // off-beat data toggles so a stale capture shows up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tog <= 1'h0;
      mem_ready <= 1'h0;
      mem_rdata <= 32'h0;
    end else begin
      tog <= ~tog;
      mem_ready <= mem_valid && !mem_ready && (!slow || tog);
      mem_rdata <= (mem_valid && !mem_ready) ? mem_addr ^ salt : ~mem_rdata;
    end
  end
endmodule : ucc_mem_model
`default_nettype wire

// [verif/ucc_top_asserts.sv]
// port checker for the cache controller
// assumes one clock domain and bind into ucc_top
`timescale 1ns/10ps
`default_nettype none
module ucc_asserts
  import ucc_pkg::*;
#(parameter int WAYS = UCC_WAYS, parameter int SETS = UCC_SETS) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire ucc_req_t core_req,
  input wire logic core_ready,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [UCC_ADDR_W-1:0] mem_addr,
  input wire logic [UCC_DATA_W-1:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic cache_status_bit,
  input wire logic [1:0] monitor_mode,
  input wire logic monitor_enable_bit,
  input wire logic monitor_clear_bit,
  input wire logic [UCC_CNT_W-1:0] monitor_count_field
);
  // ---------------------
  // properties
  // ---------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_MEM_HOLD: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
    && $stable(mem_write)) else $error("master request dropped");
  AST_FWD: assert property (
    mem_valid && (mem_write || !cache_status_bit) |-> mem_addr == core_req.addr
    && (!mem_write || mem_wdata == core_req.wdata)) else $error("not forwarded");
  AST_FILL_BASE: assert property (
    $rose(mem_valid) && !mem_write && cache_status_bit |-> mem_addr[3:0] == 4'h0
  ) else $error("fill not at line base");
  AST_FILL_STEP: assert property (
    mem_valid && mem_ready && !mem_write && cache_status_bit
    && mem_addr[3:2] != 2'h3 |=> mem_valid && mem_addr == $past(mem_addr) + 32'h4
  ) else $error("fill beat order");
  AST_BYP_DONE: assert property (
    mem_valid && mem_ready && (mem_write || !cache_status_bit)
    |-> ##[1:2] core_ready) else $error("forwarded access not answered");
  AST_CLR: assert property (
    clk_en && monitor_clear_bit |=> monitor_count_field == 32'h0
  ) else $error("no clear");
  AST_CYC: assert property (
    clk_en && monitor_enable_bit && !monitor_clear_bit
    && monitor_mode == UCC_MODE_CYCLE
    |=> monitor_count_field == $past(monitor_count_field) + 32'h1
  ) else $error("cycle count step");
  AST_STS_IDLE: assert property (
    $fell(cache_status_bit) |-> !mem_valid && !$past(mem_valid)
  ) else $error("disabled while busy");
endmodule : ucc_asserts
bind ucc_top ucc_asserts #(.WAYS(WAYS), .SETS(SETS)) ucc_asserts_i (
  .core_clk, .rst, .clk_en, .core_req, .core_ready, .mem_valid, .mem_write,
  .mem_addr, .mem_wdata, .mem_ready, .cache_status_bit, .monitor_mode,
  .monitor_enable_bit, .monitor_clear_bit, .monitor_count_field);
`default_nettype wire

// [verif/test_unified_cache_controller.sv]
// self-checking bench: core accesses, maintenance bits, monitor counter
// assumes ucc_mem_model on the master port, data = address ^ salt
`timescale 1ns/10ps
`default_nettype none
module test_unified_cache_controller;
  import ucc_pkg::*;
  logic core_clk, rst, core_valid, core_ready, mem_valid, mem_write, mem_ready;
  logic cache_enable_bit, cache_status_bit, invalidate_all_bit, inval_line_wr;
  logic monitor_enable_bit, monitor_clear_bit, slow, clk_en;
  logic [1:0] monitor_mode;
  logic [31:0] core_rdata, mem_addr, mem_wdata, mem_rdata, salt, rd;
  logic [31:0] monitor_count_field;
  ucc_req_t core_req;
  ucc_inval_t inval_line;
  int miscompares = 0, n_compared = 0, nb = 0;
  ucc_top ucc_top_i (.core_clk, .rst, .clk_en, .core_valid, .core_req,
    .core_ready, .core_rdata, .mem_valid, .mem_write, .mem_addr, .mem_wdata,
    .mem_ready, .mem_rdata, .cache_enable_bit, .cache_status_bit,
    .invalidate_all_bit, .inval_line_wr, .inval_line, .monitor_mode,
    .monitor_enable_bit, .monitor_clear_bit, .monitor_count_field);
  ucc_mem_model ucc_mem_model_i (.core_clk, .rst, .slow, .salt, .mem_valid,
    .mem_addr, .mem_ready, .mem_rdata);
  // ---------------------
  // tasks
  // ---------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (mem_valid && mem_ready) nb++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one core access; expected master beats checked too
  task automatic acc(input logic w, i, input logic [31:0] a, input int bt);
    int n;
    n = 0;
    nb = 0;
    core_valid <= 1'b1;
    core_req <= '{a, w, i, 32'hC0DE0000 | a};
    do begin
      @(posedge core_clk);
      n++;
    end while (core_ready !== 1'b1 && n < 60);
    chk(core_ready, 1'b1);
    rd = core_rdata;
    core_valid <= 1'b0;
    @(posedge core_clk);
    chk(nb, bt);
    if (!w) chk(rd, a ^ salt);
  endtask : acc
  task automatic sts(input logic v);
    int n;
    n = 0;
    while (cache_status_bit !== v && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk(cache_status_bit, v);
  endtask : sts
  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // ---------------------
  // sequence
  // ---------------------
  initial begin
    rst = 1'b1;
    {core_valid, invalidate_all_bit, inval_line_wr, slow} = 4'h0;
    {monitor_enable_bit, monitor_clear_bit, monitor_mode} = 4'h0;
    core_req = '0;
    inval_line = '0;
    cache_enable_bit = 1'b1;
    clk_en = 1'b1;
    salt = 32'h5A5A0000;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(cache_status_bit, 32'h1);
    acc(0, 1, 32'h104, 4);
    acc(0, 0, 32'h108, 0);
    acc(1, 0, 32'h10C, 1);
    acc(0, 1, 32'h10C, 0);
    slow <= 1'b1;
    for (int k = 1; k < 5; k++) acc(0, 0, 32'h100 + k * 32'h200, 4);
    acc(0, 0, 32'h300, 0);
    acc(0, 0, 32'h100, 4);
    acc(0, 0, 32'h300, 4);
    salt <= 32'h0F0F0000;
    invalidate_all_bit <= 1'b1;
    @(posedge core_clk);
    invalidate_all_bit <= 1'b0;
    acc(0, 0, 32'h300, 4);
    for (int k = 0; k < 4; k++) acc(0, 0, 32'h2070 + k * 32'h200, 4);
    for (int w = 0; w < 4; w++) begin
      cache_enable_bit <= 1'b0;
      sts(1'b0);
      inval_line_wr <= 1'b1;
      inval_line <= '{w[1:0], 5'h07};
      @(posedge core_clk);
      inval_line_wr <= 1'b0;
      cache_enable_bit <= 1'b1;
      sts(1'b1);
      acc(0, 0, 32'h2070 + w * 32'h200, 4);
      for (int k = 0; k < 4; k++) acc(0, 1, 32'h2070 + k * 32'h200, 0);
    end
    cache_enable_bit <= 1'b0;
    sts(1'b0);
    acc(0, 0, 32'h2070, 1);
    acc(1, 0, 32'h2074, 1);
    cache_enable_bit <= 1'b1;
    sts(1'b1);
    acc(0, 0, 32'h2070, 0);
    for (int m = 0; m < 3; m++) begin
      monitor_mode <= m[1:0];
      monitor_clear_bit <= 1'b1;
      @(posedge core_clk);
      monitor_clear_bit <= 1'b0;
      monitor_enable_bit <= 1'b1;
      if (m == 0) begin
        repeat (10) @(posedge core_clk);
        // frozen cycles must not count
        clk_en <= 1'b0;
        repeat (5) @(posedge core_clk);
        clk_en <= 1'b1;
      end else begin
        acc(0, 1, 32'h2070, 0);
        acc(0, 0, 32'h2074, 0);
        acc(0, 0, 32'h2078, 0);
      end
      monitor_enable_bit <= 1'b0;
      @(posedge core_clk);
      chk(monitor_count_field, m == 0 ? 32'hA : 32'(m));
    end
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule : test_unified_cache_controller
`default_nettype wire
